//--- hdl/smq_defines.svh
// Register offsets, field positions, reset values and the clock period in nanoseconds of the queued serial master.
`ifndef SMQ_DEFINES_SVH
`define SMQ_DEFINES_SVH
`define SMQ_ADDR_CONFIG 8'hFC
`define SMQ_ADDR_MASKS 8'hFD
`define SMQ_ADDR_STATUS 8'hFE
`define SMQ_ADDR_PORT 8'hFF
`define SMQ_CONFIG_RESET 7'h20
`define SMQ_MASKS_RESET 4'hF
`define SMQ_PORT_RESET 8'h00
`define SMQ_CFG_DIV_HI 6
`define SMQ_CFG_DIV_LO 4
`define SMQ_CFG_ORDER 3
`define SMQ_CFG_IDLE 2
`define SMQ_CFG_PHASE 1
`define SMQ_CFG_ON 0
`define SMQ_ST_RX_FULL 3
`define SMQ_ST_RX_AVAIL 2
`define SMQ_ST_TX_EMPTY 1
`define SMQ_ST_TX_SPACE 0
`define SMQ_CLK_PERIOD_NS 4
`endif

//--- hdl/smq_master.sv
// Serial peripheral master with two-entry transmit and receive queues on a byte register port.
`timescale 1ns/1ps
`include "smq_defines.svh"

module smq_master
    import smq_pkg::*;
#(
    parameter int QUEUE_DEPTH = 2
) (
    // Clock and reset.
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    // Register port.
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    // Serial link.
    output logic SERIAL_CLOCK_OUT_O,
    output logic SERIAL_DATA_OUT_O,
    input wire logic SERIAL_DATA_IN_I,
    // Interrupt request.
    output logic IRQ_O
);

    if (QUEUE_DEPTH != 2) begin : g_depth_check
        $error("QUEUE_DEPTH must be 2");
    end

    logic [6:0] master_config_main_reg;
    logic [3:0] master_interrupt_masks_reg;
    logic [7:0] tx_mem [0:1];
    logic [7:0] rx_mem [0:1];
    logic [1:0] tx_count_reg;
    logic [1:0] rx_count_reg;
    logic tx_rd_ptr_reg;
    logic tx_wr_ptr_reg;
    logic rx_rd_ptr_reg;
    logic rx_wr_ptr_reg;
    smq_state_t state_reg;
    logic [5:0] div_cnt_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_shift_reg;
    logic byte_done;
    logic half_tick;
    logic tx_pop;
    logic port_wr;
    logic port_rd;
    logic master_core_on;
    logic bit_order_select;
    logic serial_clock_idle_level;
    logic sample_edge_select;
    logic [2:0] serial_clock_divider;
    logic receive_queue_full;
    logic receive_byte_available;
    logic transmit_queue_empty;
    logic transmit_space_available;
    logic [3:0] status_now;
    logic [7:0] rx_byte;
    logic sample_now;
    logic sample_pend_reg;
    logic done_pend_reg;
    logic rx_push;

    // Half period of the serial clock in processor cycles, minus one.
    function automatic logic [5:0] half_limit(input logic [2:0] div);
        unique case (div)
            3'h0: half_limit = 6'h00;
            3'h1: half_limit = 6'h01;
            3'h2: half_limit = 6'h03;
            3'h3: half_limit = 6'h07;
            3'h4: half_limit = 6'h0F;
            default: half_limit = 6'h1F;
        endcase
    endfunction

    // Bit that leaves or enters first in the selected order.
    function automatic logic out_bit(input logic [7:0] b, input logic lsb_first);
        out_bit = lsb_first ? b[0] : b[7];
    endfunction

    assign serial_clock_divider = master_config_main_reg[`SMQ_CFG_DIV_HI:`SMQ_CFG_DIV_LO];
    assign bit_order_select = master_config_main_reg[`SMQ_CFG_ORDER];
    assign serial_clock_idle_level = master_config_main_reg[`SMQ_CFG_IDLE];
    assign sample_edge_select = master_config_main_reg[`SMQ_CFG_PHASE];
    assign master_core_on = master_config_main_reg[`SMQ_CFG_ON];

    assign receive_queue_full = (rx_count_reg == 2'h2);
    assign receive_byte_available = (rx_count_reg != 2'h0);
    assign transmit_queue_empty = (tx_count_reg == 2'h0);
    assign transmit_space_available = (tx_count_reg != 2'h2);
    assign status_now = {receive_queue_full, receive_byte_available,
                         transmit_queue_empty, transmit_space_available};

    assign port_wr = REG_WR_I && (REG_ADDR_I == `SMQ_ADDR_PORT) && transmit_space_available;
    assign port_rd = REG_RD_I && (REG_ADDR_I == `SMQ_ADDR_PORT) && receive_byte_available;

    assign half_tick = master_core_on && (state_reg != SMQ_IDLE)
                       && (div_cnt_reg == half_limit(serial_clock_divider));
    assign byte_done = half_tick && (state_reg == SMQ_TRAIL) && (bit_cnt_reg == 3'h7);
    assign tx_pop = master_core_on && (state_reg == SMQ_IDLE) && !transmit_queue_empty;
    assign sample_now = half_tick && ((state_reg == SMQ_LEAD) != sample_edge_select);
    assign rx_push = done_pend_reg && (!receive_queue_full || port_rd);

    // Input shift register with the pending sampled bit taken in.
    always_comb begin
        rx_byte = rx_shift_reg;
        if (sample_pend_reg) begin
            rx_byte = bit_order_select ? {SERIAL_DATA_IN_I, rx_shift_reg[7:1]}
                                       : {rx_shift_reg[6:0], SERIAL_DATA_IN_I};
        end
    end

    // The pins lag the bit engine by one cycle, so input is taken one cycle after its edge.
    // Sampling at the internal edge would miss the slave's new bit at divide by two.
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            sample_pend_reg <= 1'b0;
            done_pend_reg <= 1'b0;
            rx_shift_reg <= 8'h00;
        end else begin
            sample_pend_reg <= sample_now;
            done_pend_reg <= byte_done;
            rx_shift_reg <= rx_byte;
        end
    end

    // Configuration and mask registers.
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            master_config_main_reg <= `SMQ_CONFIG_RESET;
            master_interrupt_masks_reg <= `SMQ_MASKS_RESET;
        end else if (REG_WR_I) begin
            if (REG_ADDR_I == `SMQ_ADDR_CONFIG) begin
                master_config_main_reg <= REG_WDATA_I[6:0];
            end
            if (REG_ADDR_I == `SMQ_ADDR_MASKS) begin
                master_interrupt_masks_reg <= REG_WDATA_I[3:0];
            end
        end
    end

    // Transmit queue.
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            tx_count_reg <= 2'h0;
            tx_rd_ptr_reg <= 1'b0;
            tx_wr_ptr_reg <= 1'b0;
            tx_mem[0] <= `SMQ_PORT_RESET;
            tx_mem[1] <= `SMQ_PORT_RESET;
        end else begin
            if (port_wr) begin
                tx_mem[tx_wr_ptr_reg] <= REG_WDATA_I;
                tx_wr_ptr_reg <= ~tx_wr_ptr_reg;
            end
            if (tx_pop) begin
                tx_rd_ptr_reg <= ~tx_rd_ptr_reg;
            end
            tx_count_reg <= tx_count_reg + {1'b0, port_wr} - {1'b0, tx_pop};
        end
    end

    // Receive queue; a byte arriving while full overwrites nothing and is dropped, unless the port is read in the same cycle.
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rx_count_reg <= 2'h0;
            rx_rd_ptr_reg <= 1'b0;
            rx_wr_ptr_reg <= 1'b0;
            rx_mem[0] <= `SMQ_PORT_RESET;
            rx_mem[1] <= `SMQ_PORT_RESET;
        end else begin
            if (rx_push) begin
                rx_mem[rx_wr_ptr_reg] <= rx_byte;
                rx_wr_ptr_reg <= ~rx_wr_ptr_reg;
            end
            if (port_rd) begin
                rx_rd_ptr_reg <= ~rx_rd_ptr_reg;
            end
            rx_count_reg <= rx_count_reg + {1'b0, rx_push} - {1'b0, port_rd};
        end
    end

    // Read data; reading status has no side effect.
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                `SMQ_ADDR_CONFIG: REG_RDATA_O <= {1'b0, master_config_main_reg};
                `SMQ_ADDR_MASKS: REG_RDATA_O <= {4'h0, master_interrupt_masks_reg};
                `SMQ_ADDR_STATUS: REG_RDATA_O <= {4'h0, status_now};
                `SMQ_ADDR_PORT: REG_RDATA_O <= rx_mem[rx_rd_ptr_reg];
                default: REG_RDATA_O <= 8'h00;
            endcase
        end
    end

    // Interrupt request from unmasked sources.
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(status_now & ~master_interrupt_masks_reg);
        end
    end

    // Bit engine: one serial period is a leading half and a trailing half.
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_reg <= SMQ_IDLE;
            div_cnt_reg <= 6'h00;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else if (master_core_on) begin
            unique case (state_reg)
                SMQ_IDLE: begin
                    div_cnt_reg <= 6'h00;
                    bit_cnt_reg <= 3'h0;
                    if (tx_pop) begin
                        shift_reg <= tx_mem[tx_rd_ptr_reg];
                        state_reg <= SMQ_LEAD;
                    end
                end
                SMQ_LEAD: begin
                    div_cnt_reg <= half_tick ? 6'h00 : div_cnt_reg + 6'h01;
                    if (half_tick) begin
                        state_reg <= SMQ_TRAIL;
                        if (sample_edge_select && (bit_cnt_reg != 3'h0)) begin
                            shift_reg <= bit_order_select ? {1'b0, shift_reg[7:1]}
                                                          : {shift_reg[6:0], 1'b0};
                        end
                    end
                end
                SMQ_TRAIL: begin
                    div_cnt_reg <= half_tick ? 6'h00 : div_cnt_reg + 6'h01;
                    if (half_tick) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        state_reg <= (bit_cnt_reg == 3'h7) ? SMQ_IDLE : SMQ_LEAD;
                        if (!sample_edge_select) begin
                            shift_reg <= bit_order_select ? {1'b0, shift_reg[7:1]}
                                                          : {shift_reg[6:0], 1'b0};
                        end
                    end
                end
                default: state_reg <= SMQ_IDLE;
            endcase
        end
    end

    // Serial clock and data pins.
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            SERIAL_CLOCK_OUT_O <= 1'b0;
            SERIAL_DATA_OUT_O <= 1'b0;
        end else begin
            SERIAL_CLOCK_OUT_O <= serial_clock_idle_level
                                  ^ (state_reg == SMQ_TRAIL) ;
            SERIAL_DATA_OUT_O <= out_bit(shift_reg, bit_order_select);
        end
    end

    chk_rx_full_flag: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        receive_queue_full |-> receive_byte_available)
        else $error("receive full without available data");

    chk_tx_flags: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        transmit_queue_empty |-> transmit_space_available)
        else $error("transmit empty without space");

    chk_irq_masked: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (master_interrupt_masks_reg == 4'hF) ##1 (master_interrupt_masks_reg == 4'hF)
        |-> !IRQ_O)
        else $error("interrupt despite full mask");

    chk_irq_source: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        ((status_now & ~master_interrupt_masks_reg) != 4'h0) |=> IRQ_O)
        else $error("unmasked source gave no interrupt");

    chk_core_stopped: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        !master_core_on |=> $stable(state_reg))
        else $error("core moved while disabled");

    chk_idle_clock: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (state_reg == SMQ_IDLE)
        |=> SERIAL_CLOCK_OUT_O == $past(serial_clock_idle_level))
        else $error("serial clock not at idle level");

    chk_start_xfer: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        master_core_on && (state_reg == SMQ_IDLE) && !transmit_queue_empty
        |=> state_reg == SMQ_LEAD)
        else $error("queued byte not started");

    chk_port_push: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        port_wr && !tx_pop |=> tx_count_reg == $past(tx_count_reg) + 2'h1)
        else $error("port write did not push");

    chk_rx_push: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        rx_push && !port_rd |=> rx_count_reg == $past(rx_count_reg) + 2'h1)
        else $error("received byte not queued");

endmodule // smq_master

//--- hdl/smq_pkg.sv
// Types of the queued serial master.
package smq_pkg;
    typedef enum logic [2:0] {
        SMQ_IDLE = 3'b001,
        SMQ_LEAD = 3'b010,
        SMQ_TRAIL = 3'b100
    } smq_state_t;
endpackage

//--- tb/smq_slave_model.sv
// Behavioural serial slave that answers the queued serial master.
`timescale 1ns/1ps
module smq_slave_model (
    // Clock and serial link.
    input wire logic clk_i,
    input wire logic sclk_i,
    input wire logic sdo_i,
    output logic sdi_o,
    // Mode and frame alignment.
    input wire logic idle_i,
    input wire logic phase_i,
    input wire logic order_i,
    input wire logic sync_i
);
    logic [7:0] rx_mem [16];
    logic [7:0] shreg = 8'h00;
    logic prev = 1'b0;
    int n = 0;
    int count = 0;
    int cyc = 0;
    int half_len = 0;
    function automatic logic [7:0] tx_byte(input int k);
        return 8'h5A + 8'(k) * 8'h25;
    endfunction
    function automatic int pos(input int b);
        return order_i ? b : 7 - b;
    endfunction
    // No select line exists; frames are counted from clock edges, with sync_i clearing the bit count.
    always @(negedge clk_i) begin
        logic [7:0] tx;
        tx = tx_byte(count);
        if (sync_i) begin
            n = 0;
        end else if (sclk_i != prev) begin
            half_len = cyc;
            cyc = 1;
            if ((sclk_i != idle_i) != phase_i) begin
                shreg[pos(n)] = sdo_i;
                n = n + 1;
                if (n == 8) begin
                    rx_mem[count[3:0]] = shreg;
                    count = count + 1;
                    n = 0;
                end
            end else begin
                sdi_o = tx[pos(n)];
            end
        end else begin
            cyc = cyc + 1;
        end
        // Between frames the line is not held: preload or keep it moving.
        if (n == 0 && sclk_i == idle_i && sclk_i == prev) begin
            sdi_o = phase_i ? ~sdi_o : tx[pos(0)];
        end
        prev = sclk_i;
    end
endmodule // smq_slave_model

//--- tb/tb_smq_master.sv
// Self-checking bench for the queued serial master.
`timescale 1ns/1ps
`include "smq_defines.svh"
module tb_smq_master;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic sclk;
    logic sdo;
    logic sdi;
    logic irq;
    logic idle = 1'b0;
    logic phase = 1'b0;
    logic order = 1'b0;
    logic sync = 1'b1;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int base;
    logic [7:0] cfg;
    logic [7:0] sent [2];
    logic [3:0] mk [5] = '{4'hF, 4'hE, 4'hD, 4'h3, 4'h0};
    logic [4:0] ex = 5'b10110;
    smq_master i_smq_master (.MCLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SERIAL_CLOCK_OUT_O(sclk),
        .SERIAL_DATA_OUT_O(sdo), .SERIAL_DATA_IN_I(sdi), .IRQ_O(irq));
    smq_slave_model i_smq_slave_model (.clk_i(clk), .sclk_i(sclk), .sdo_i(sdo), .sdi_o(sdi),
        .idle_i(idle), .phase_i(phase), .order_i(order), .sync_i(sync));
    always #2 clk = ~clk;
    task automatic give_verdict();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check(rdata, exp);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        reg_read(`SMQ_ADDR_CONFIG, 8'h20);
        reg_read(`SMQ_ADDR_MASKS, 8'h0F);
        reg_read(`SMQ_ADDR_STATUS, 8'h03);
        reg_read(`SMQ_ADDR_PORT, 8'h00);
        reg_read(8'h10, 8'h00);
        reg_write(`SMQ_ADDR_STATUS, 8'h00);
        reg_read(`SMQ_ADDR_STATUS, 8'h03);
        for (int i = 0; i < 8; i++) begin
            {phase, idle, order} = 3'(i);
            cfg = {1'b0, 3'(i), order, idle, phase, 1'b0};
            sync = 1'b1;
            reg_write(`SMQ_ADDR_CONFIG, cfg);
            repeat (3) @(negedge clk);
            check({7'h00, sclk}, {7'h00, idle});
            base = i_smq_slave_model.count;
            sent[0] = 8'hC3 ^ 8'(i * 7);
            sent[1] = 8'h81 + 8'(i);
            reg_write(`SMQ_ADDR_PORT, sent[0]);
            reg_write(`SMQ_ADDR_PORT, sent[1]);
            reg_write(`SMQ_ADDR_PORT, 8'hFF);
            reg_read(`SMQ_ADDR_STATUS, 8'h00);
            repeat (20) @(negedge clk);
            check(8'(i_smq_slave_model.count - base), 8'h00);
            sync = 1'b0;
            reg_write(`SMQ_ADDR_CONFIG, cfg | 8'h01);
            for (int w = 0; w < 3000 && i_smq_slave_model.count < base + 2; w++) begin
                @(negedge clk);
            end
            repeat (40) @(negedge clk);
            check(8'(i_smq_slave_model.count - base), 8'h02);
            check(i_smq_slave_model.rx_mem[base % 16], sent[0]);
            check(i_smq_slave_model.rx_mem[(base + 1) % 16], sent[1]);
            check(8'(i_smq_slave_model.half_len), 8'(1 << (i > 5 ? 5 : i)));
            reg_read(`SMQ_ADDR_STATUS, 8'h0F);
            reg_read(`SMQ_ADDR_STATUS, 8'h0F);
            reg_write(`SMQ_ADDR_MASKS, 8'h07);
            repeat (3) @(negedge clk);
            check({7'h00, irq}, 8'h01);
            reg_write(`SMQ_ADDR_MASKS, 8'h0F);
            reg_read(`SMQ_ADDR_PORT, i_smq_slave_model.tx_byte(base));
            reg_read(`SMQ_ADDR_STATUS, 8'h07);
            reg_read(`SMQ_ADDR_PORT, i_smq_slave_model.tx_byte(base + 1));
            reg_read(`SMQ_ADDR_STATUS, 8'h03);
        end
        reg_write(`SMQ_ADDR_CONFIG, 8'h20);
        for (int m = 0; m < 5; m++) begin
            reg_write(`SMQ_ADDR_MASKS, {4'h0, mk[m]});
            repeat (3) @(negedge clk);
            check({7'h00, irq}, {7'h00, ex[m]});
        end
        reg_read(`SMQ_ADDR_MASKS, 8'h00);
        give_verdict();
    end
endmodule // tb_smq_master
